// ==== verilog/qms_core.sv ====
// command interpreter: mode switch, wrapped read addressing, soft reset
// assumes the array engine consumes rdAddr/rdStrobe and owns the data output
`timescale 1ns/100ps

// Overview of operation
// - four-wire 0Ch reads like 0Bh, wrapping
// - wrap length from last C0h or 77h, dummies from last C0h
// - power-up starts in serial mode
// - one mode at a time, one command format per mode
// - 38h enters four-wire only with quad_enable_bit
// - entering keeps latch, suspend, wrap length
// - FFh in four-wire mode returns serial
// - leaving keeps latch, suspend, wrap length
// - reset needs 66h then 99h, either mode
// - other command after 66h disarms
// - accepted reset clears all volatile settings
// - no commands during 30 us recovery
// - defaults: 8-byte wrap, 2 dummy clocks
// - serial mode rejects C0h
module qms_core (
	// system clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// serial link pins
	input  wire logic        sclk,
	input  wire logic        csn,
	input  wire logic [3:0]  io,
	// status from the status register
	input  wire logic        quadEnable,
	// mode and settings
	output wire logic        quadMode,
	output wire logic [7:0]  readParam,
	output wire logic [2:0]  wrapSetting,
	output wire logic [3:0]  dummyClocks,
	// reset control
	output wire logic        busy,
	output wire logic        softReset,
	// read addressing toward the array
	output wire logic [23:0] rdAddr,
	output wire logic        rdStrobe
);

	// dummy bytes in four-wire mode: two clocks per byte
	function automatic logic [2:0] dummyBytes(input logic [1:0] sel);
		dummyBytes = {1'b0, sel} + 3'h1;
	endfunction

	// next read address, wrapping inside an aligned window
	function automatic logic [23:0] nextAddr(input logic [23:0] a,
		input logic [1:0] len, input logic wrap);
		logic [23:0] m;
		m = (24'h000008 << len) - 24'h000001;
		nextAddr = wrap ? ((a & ~m) | ((a + 24'h000001) & m)) : (a + 24'h000001);
	endfunction

	qms_pkg::qms_link_s lnk;  // bytes from the link clock
	logic serPulse;           // serial byte arrived
	logic quadPulse;          // four-wire byte arrived

	// link-clock byte assembly
	qms_link uLink (
		.sclk (sclk),
		.csn  (csn),
		.rstn (rstn),
		.io   (io),
		.lnk  (lnk)
	);

	// serial byte crossing
	qms_toggle_sync uSerSync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.tgl     (lnk.serTgl),
		.pulse   (serPulse)
	);

	// four-wire byte crossing
	qms_toggle_sync uQuadSync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.tgl     (lnk.quadTgl),
		.pulse   (quadPulse)
	);

	logic              csnS1_r;     // first sync stage of chip select
	logic              csnS2_r;     // synchronised chip select
	logic              csnS3_r;     // delayed so the last byte lands first
	logic              csnS4_r;     // history for edge detect
	logic              quadMode_r;  // four-wire command mode
	logic              armed_r;     // reset armed
	logic [7:0]        readParam_r; // read parameter bits
	logic [2:0]        wrapSet_r;   // wrap setting bits
	logic [1:0]        wrapLen_r;   // active wrap length code
	logic [10:0]       recCnt_r;    // recovery cycles left
	logic              softRst_r;   // reset accepted pulse
	qms_pkg::qms_phase_e phase_r;   // command phase
	qms_pkg::qms_phase_e phase_nxt; // next command phase
	logic [7:0]        opc_r;       // opcode of current frame
	logic              gotOpc_r;    // opcode byte received
	logic [7:0]        parByte_r;   // parameter byte
	logic              parOk_r;     // parameter byte received
	logic [1:0]        cnt_r;       // address / dummy byte count
	logic [23:0]       addr_r;      // running read address
	logic              wrapOn_r;    // current read wraps
	logic [23:0]       rdAddr_r;    // address handed to the array
	logic              rdStb_r;     // address strobe

	// chip select synchroniser and delay line
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			csnS1_r <= 1'b1;
			csnS2_r <= 1'b1;
			csnS3_r <= 1'b1;
			csnS4_r <= 1'b1;
		end else begin
			csnS1_r <= csn;
			csnS2_r <= csnS1_r;
			csnS3_r <= csnS2_r;
			csnS4_r <= csnS3_r;
		end
	end

	// decode of bytes and frame ends
	wire       busyW     = (recCnt_r != 11'h000);
	wire       frameEnd  = csnS3_r & ~csnS4_r;
	wire       byteEv    = (quadMode_r ? quadPulse : serPulse) & ~busyW;
	wire [7:0] byteVal   = quadMode_r ? lnk.quadByte : lnk.serByte;
	wire       exec      = frameEnd & ~busyW & gotOpc_r;
	wire       doReset   = exec & (opc_r == qms_pkg::OPC_RST_GO) & armed_r;
	wire       doEnter   = exec & (opc_r == qms_pkg::OPC_ENTER_QW) & ~quadMode_r
		& quadEnable;
	wire       doExit    = exec & (opc_r == qms_pkg::OPC_EXIT_QW) & quadMode_r;
	wire       doParam   = exec & (opc_r == qms_pkg::OPC_SET_PARAM) & quadMode_r
		& parOk_r;
	wire       doWrapSet = exec & (opc_r == qms_pkg::OPC_SET_WRAP) & ~quadMode_r
		& parOk_r;
	wire       isRead    = quadMode_r & ((byteVal == qms_pkg::OPC_WRAP_READ)
		| (byteVal == qms_pkg::OPC_FAST_READ));
	wire       takesPar  = quadMode_r ? (byteVal == qms_pkg::OPC_SET_PARAM)
		: (byteVal == qms_pkg::OPC_SET_WRAP);
	wire [1:0] dumSel    = readParam_r[qms_pkg::PRM_DUMMY_LSB +: 2];
	wire       dumLast   = ({1'b0, cnt_r} == (dummyBytes(dumSel) - 3'h1));
	wire       emit      = byteEv & (((phase_r == qms_pkg::PH_DUMMY) & dumLast)
		| (phase_r == qms_pkg::PH_DATA));

	// command phase sequencing within a frame
	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			qms_pkg::PH_OPC: begin
				if (byteEv) begin
					phase_nxt = isRead ? qms_pkg::PH_ADDR
						: (takesPar ? qms_pkg::PH_PARAM : qms_pkg::PH_SKIP);
				end
			end
			qms_pkg::PH_ADDR: begin
				if (byteEv && cnt_r == qms_pkg::ADDR_LAST) begin
					phase_nxt = qms_pkg::PH_DUMMY;
				end
			end
			qms_pkg::PH_DUMMY: begin
				if (byteEv && dumLast) begin
					phase_nxt = qms_pkg::PH_DATA;
				end
			end
			qms_pkg::PH_PARAM: begin
				if (byteEv) begin
					phase_nxt = qms_pkg::PH_SKIP;
				end
			end
			qms_pkg::PH_DATA,
			qms_pkg::PH_SKIP: begin
				phase_nxt = phase_r;
			end
			default: begin
				phase_nxt = qms_pkg::PH_OPC;
			end
		endcase
		if (frameEnd || busyW) begin
			phase_nxt = qms_pkg::PH_OPC;
		end
	end

	// phase register and per-frame captures
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			phase_r   <= qms_pkg::PH_OPC;
			opc_r     <= 8'h00;
			gotOpc_r  <= 1'b0;
			parByte_r <= 8'h00;
			parOk_r   <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			if (frameEnd) begin
				gotOpc_r <= 1'b0;
				parOk_r  <= 1'b0;
			end else if (byteEv && phase_r == qms_pkg::PH_OPC) begin
				opc_r    <= byteVal;
				gotOpc_r <= 1'b1;
			end else if (byteEv && phase_r == qms_pkg::PH_PARAM) begin
				parByte_r <= byteVal;
				parOk_r   <= 1'b1;
			end
		end
	end

	// address collection and wrapped advance
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_r    <= 2'h0;
			addr_r   <= 24'h000000;
			wrapOn_r <= 1'b0;
		end else if (byteEv && phase_r == qms_pkg::PH_OPC) begin
			cnt_r    <= 2'h0;
			wrapOn_r <= (byteVal == qms_pkg::OPC_WRAP_READ);
		end else if (byteEv && phase_r == qms_pkg::PH_ADDR) begin
			cnt_r  <= (cnt_r == qms_pkg::ADDR_LAST) ? 2'h0 : cnt_r + 2'h1;
			addr_r <= {addr_r[15:0], byteVal};
		end else if (emit) begin
			addr_r <= nextAddr(addr_r, wrapLen_r, wrapOn_r);
		end else if (byteEv && phase_r == qms_pkg::PH_DUMMY) begin
			cnt_r <= cnt_r + 2'h1;
		end
	end

	// address handed to the array at the start of each data byte
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdAddr_r <= 24'h000000;
			rdStb_r  <= 1'b0;
		end else begin
			rdStb_r <= emit;
			if (emit) begin
				rdAddr_r <= addr_r;
			end
		end
	end

	// mode register, only the enter, exit and reset commands move it
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			quadMode_r <= 1'b0;
		end else if (doReset) begin
			quadMode_r <= 1'b0;
		end else if (doEnter) begin
			quadMode_r <= 1'b1;
		end else if (doExit) begin
			quadMode_r <= 1'b0;
		end
	end

	// reset arming: any executed command other than arm disarms
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			armed_r <= 1'b0;
		end else if (exec) begin
			armed_r <= (opc_r == qms_pkg::OPC_RST_ARM);
		end
	end

	// volatile read settings, untouched by mode switches
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			readParam_r <= qms_pkg::READ_PARAM_RST;
			wrapSet_r   <= qms_pkg::WRAP_SET_RST;
			wrapLen_r   <= qms_pkg::WRAP_LEN_RST;
		end else if (doReset) begin
			readParam_r <= qms_pkg::READ_PARAM_RST;
			wrapSet_r   <= qms_pkg::WRAP_SET_RST;
			wrapLen_r   <= qms_pkg::WRAP_LEN_RST;
		end else if (doParam) begin
			readParam_r <= parByte_r;
			wrapLen_r   <= parByte_r[qms_pkg::PRM_WRAP_LSB +: 2];
		end else if (doWrapSet) begin
			wrapSet_r <= parByte_r[qms_pkg::WRS_LSB +: 3];
			wrapLen_r <= parByte_r[qms_pkg::WRS_LEN_LSB +: 2];
		end
	end

	// recovery counter, loaded on an accepted reset
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			recCnt_r  <= 11'h000;
			softRst_r <= 1'b0;
		end else begin
			softRst_r <= doReset;
			if (doReset) begin
				recCnt_r <= qms_pkg::RST_RECOVERY_CYC;
			end else if (busyW) begin
				recCnt_r <= recCnt_r - 11'h001;
			end
		end
	end

	// outputs
	assign quadMode    = quadMode_r;
	assign readParam   = readParam_r;
	assign wrapSetting = wrapSet_r;
	assign dummyClocks = {dummyBytes(dumSel), 1'b0};
	assign busy        = busyW;
	assign softReset   = softRst_r;
	assign rdAddr      = rdAddr_r;
	assign rdStrobe    = rdStb_r;

	// helper: length of each busy period
	logic [10:0] busyLen_r; // cycles busy so far
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			busyLen_r <= 11'h000;
		end else begin
			busyLen_r <= busyW ? busyLen_r + 11'h001 : 11'h000;
		end
	end

	// reset acceptance followed by a busy stretch
	sequence sAcceptReset;
		doReset ##1 softRst_r && busyW;
	endsequence
	sequence sStayBusy;
		busyW [*8];
	endsequence

	chk_power_serial: assert property (@(posedge clk_sys)
		!$past(rstn) |-> !quadMode_r)
		else $error("not in serial mode after power-up");
	chk_enter_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
		(exec && opc_r == qms_pkg::OPC_ENTER_QW && !quadEnable && !quadMode_r)
		|=> !quadMode_r)
		else $error("entered four-wire mode without quad enable");
	chk_mode_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
		$changed(quadMode_r) |-> $past(doEnter || doExit || doReset))
		else $error("mode changed without a switching command");
	chk_exit_serial: assert property (@(posedge clk_sys) disable iff (!rstn)
		(exec && quadMode_r && opc_r == qms_pkg::OPC_EXIT_QW) |=> !quadMode_r)
		else $error("exit opcode did not return to serial mode");
	chk_switch_keeps: assert property (@(posedge clk_sys) disable iff (!rstn)
		(doEnter || doExit) |=> $stable(wrapLen_r) && $stable(wrapSet_r))
		else $error("mode switch changed the wrap setting");
	chk_reset_pair: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(softRst_r) |-> $past(armed_r) && $past(opc_r) == qms_pkg::OPC_RST_GO)
		else $error("reset accepted without arm");
	chk_disarm_other: assert property (@(posedge clk_sys) disable iff (!rstn)
		(exec && opc_r != qms_pkg::OPC_RST_ARM) |=> !armed_r)
		else $error("arm survived another command");
	chk_reset_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
		doReset |=> readParam_r == qms_pkg::READ_PARAM_RST && wrapSet_r == 3'h0
		&& !quadMode_r && dummyClocks == 4'h2)
		else $error("reset left a volatile setting");
	chk_busy_span: assert property (@(posedge clk_sys) disable iff (!rstn)
		sAcceptReset |=> sStayBusy)
		else $error("busy dropped early after reset");
	chk_busy_length: assert property (@(posedge clk_sys) disable iff (!rstn)
		$fell(busyW) |-> busyLen_r == qms_pkg::RST_RECOVERY_CYC)
		else $error("recovery length wrong");
	chk_serial_param: assert property (@(posedge clk_sys) disable iff (!rstn)
		(exec && opc_r == qms_pkg::OPC_SET_PARAM && !quadMode_r) |=> $stable(readParam_r))
		else $error("parameters taken in serial mode");
	chk_wrap_window: assert property (@(posedge clk_sys) disable iff (!rstn)
		(emit && wrapOn_r) |=> ((addr_r ^ rdAddr_r) >> (3 + wrapLen_r)) == 24'h000000)
		else $error("wrapped read left its window");

endmodule

// ==== verilog/qms_pkg.sv ====
// shared constants and types of the quad mode switch and soft reset block
// assumes a 50 MHz system clock and a host-driven serial clock on the link
package qms_pkg;

	// opcodes seen on the command byte
	localparam logic [7:0] OPC_FAST_READ = 8'h0B;
	localparam logic [7:0] OPC_WRAP_READ = 8'h0C;
	localparam logic [7:0] OPC_SET_PARAM = 8'hC0;
	localparam logic [7:0] OPC_SET_WRAP  = 8'h77;
	localparam logic [7:0] OPC_ENTER_QW  = 8'h38;
	localparam logic [7:0] OPC_EXIT_QW   = 8'hFF;
	localparam logic [7:0] OPC_RST_ARM   = 8'h66;
	localparam logic [7:0] OPC_RST_GO    = 8'h99;

	// field positions in the read parameter byte
	localparam int PRM_WRAP_LSB  = 0;
	localparam int PRM_DUMMY_LSB = 4;
	// field positions in the wrap setting byte
	localparam int WRS_LSB       = 4;
	localparam int WRS_LEN_LSB   = 4;

	// reset values of the volatile settings
	localparam logic [7:0] READ_PARAM_RST = 8'h00;
	localparam logic [2:0] WRAP_SET_RST   = 3'h0;
	localparam logic [1:0] WRAP_LEN_RST   = 2'h0;

	// address bytes of a read
	localparam logic [1:0] ADDR_LAST = 2'h2;

	// reset recovery time and its cycle count, rounded up
	localparam int CLK_SYS_MHZ     = 50;
	localparam int RST_RECOVERY_NS = 30000;
	localparam logic [10:0] RST_RECOVERY_CYC =
		11'((RST_RECOVERY_NS * CLK_SYS_MHZ + 999) / 1000);

	// per-frame command phase
	typedef enum logic [2:0] {
		PH_OPC,
		PH_ADDR,
		PH_DUMMY,
		PH_DATA,
		PH_PARAM,
		PH_SKIP
	} qms_phase_e;

	// bytes handed from the link clock to the system clock
	typedef struct packed {
		logic [7:0] serByte;
		logic       serTgl;
		logic [7:0] quadByte;
		logic       quadTgl;
	} qms_link_s;

endpackage

// ==== verilog/qms_toggle_sync.sv ====
// toggle-to-pulse receiver for one byte channel crossing into clk_sys
// assumes the sender holds its data stable for several clk_sys cycles
`timescale 1ns/100ps
module qms_toggle_sync (
	// system clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// toggle from the link clock
	input  wire logic tgl,
	// one-cycle pulse per toggle
	output wire logic pulse
);

	logic s1_r; // first stage, read only by s2_r
	logic s2_r; // synchronised level
	logic s3_r; // previous synchronised level

	// two-flop synchroniser plus history stage
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= tgl;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// each change of the toggle is one byte
	assign pulse = s2_r ^ s3_r;

endmodule

// ==== verilog/qms_link.sv ====
// link-clock side: assembles serial and four-wire bytes from the data lines
// assumes the host clock runs only while chip select is low
`timescale 1ns/100ps
module qms_link (
	// link clock and frame
	input  wire logic      sclk,
	input  wire logic      csn,
	input  wire logic      rstn,
	// sampled data lines
	input  wire logic [3:0] io,
	// bytes toward the system clock
	output qms_pkg::qms_link_s lnk
);

	logic [2:0] serCnt_r;  // bit count of serial byte
	logic       quadCnt_r; // nibble count of four-wire byte
	logic [6:0] serSh_r;   // serial bits so far
	logic [3:0] quadSh_r;  // high nibble so far

	// counters restart with every frame, chip select high clears them
	always_ff @(posedge sclk or posedge csn) begin
		if (csn) begin
			serCnt_r  <= 3'h0;
			quadCnt_r <= 1'b0;
		end else begin
			serCnt_r  <= serCnt_r + 3'h1;
			quadCnt_r <= ~quadCnt_r;
		end
	end

	// both formats are gathered, the system side picks one by its mode
	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			serSh_r  <= 7'h00;
			quadSh_r <= 4'h0;
		end else begin
			serSh_r  <= {serSh_r[5:0], io[0]};
			quadSh_r <= io;
		end
	end

	// finished bytes are held and announced by a toggle
	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			lnk <= '0;
		end else begin
			if (serCnt_r == 3'h7) begin
				lnk.serByte <= {serSh_r, io[0]};
				lnk.serTgl  <= ~lnk.serTgl;
			end
			if (quadCnt_r) begin
				lnk.quadByte <= {quadSh_r, io};
				lnk.quadTgl  <= ~lnk.quadTgl;
			end
		end
	end

endmodule

// ==== testbench/qms_host_model.sv ====
// host controller model: drives chip select, serial clock and data lines
// assumes the device samples data on the rising serial clock edge
`timescale 1ns/100ps
module qms_host_model (
	// system clock, used to align frame starts and to time the waits after frames and during recovery
	input  wire logic clk_sys,
	// device status seen by the host
	input  wire logic busy,
	// serial link toward the device
	output logic      csn,
	output logic      sclk,
	output logic [3:0] io
);
	localparam real HALF_NS = 24.0; // half of a 48 ns link clock

	logic [7:0] txq[$]; // bytes of the next frame

	// idle link: deselected, clock parked low
	initial begin
		csn  = 1'b1;
		sclk = 1'b0;
		io   = 4'hA;
	end

	// one frame; serial on io[0], four-wire sends the high nibble first
	task automatic frame(input logic quad);
		logic [7:0] b;
		int         nb;
		@(negedge clk_sys);
		csn = 1'b0;
		nb  = txq.size();
		for (int i = 0; i < nb; i++) begin
			b = txq[i];
			for (int k = 0; k < (quad ? 2 : 8); k++) begin
				io = quad ? ((k == 0) ? b[7:4] : b[3:0]) : {~{3{b[7-k]}}, b[7-k]};
				#(HALF_NS) sclk = 1'b1;
				#(HALF_NS) sclk = 1'b0;
			end
		end
		#(HALF_NS) csn = 1'b1;
		// released lines must not keep showing the last value
		io = ~io;
		txq.delete();
		// deselect gap plus time for the command to act
		repeat (12) @(negedge clk_sys);
	endtask

	// polite host: waits out recovery before the next command
	task automatic waitIdle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 2000) begin
			@(negedge clk_sys);
			n++;
		end
	endtask
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench for the mode switch and soft reset block
// assumes the host model frames commands and the design acts at frame end
`timescale 1ns/100ps
module tb_top;
	logic        clk_sys;     // 50 MHz system clock
	logic        rstn;        // active-low reset
	logic        csn;         // chip select from the host
	logic        sclk;        // link clock from the host
	logic [3:0]  io;          // data lines
	logic        quadEnable;  // quad enable status bit
	logic        quadMode;    // four-wire mode flag
	logic [7:0]  readParam;   // read parameter bits
	logic [2:0]  wrapSetting; // wrap setting bits
	logic [3:0]  dummyClocks; // dummy clocks in use
	logic        busy;        // recovery in progress
	logic        softReset;   // reset pulse
	logic [23:0] rdAddr;      // read address
	logic        rdStrobe;    // read strobe
	logic [16:0] stat;        // packed settings for compares
	logic [23:0] addrQ[$];    // addresses seen with each strobe
	int          busyCyc;     // length of the last busy stretch
	int          rstPulses;   // reset pulses seen
	int          n_mismatch;
	int          check_count;

	assign stat = {quadMode, busy, wrapSetting, dummyClocks, readParam};

	initial clk_sys = 1'b0;
	always #10 clk_sys = ~clk_sys;

	qms_core u_dut (.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .csn(csn), .io(io),
		.quadEnable(quadEnable), .quadMode(quadMode), .readParam(readParam),
		.wrapSetting(wrapSetting), .dummyClocks(dummyClocks), .busy(busy),
		.softReset(softReset), .rdAddr(rdAddr), .rdStrobe(rdStrobe));

	qms_host_model u_host (.clk_sys(clk_sys), .busy(busy), .csn(csn), .sclk(sclk), .io(io));

	// monitor: strobed addresses, reset pulses, busy length, read where settled
	always @(negedge clk_sys) begin
		if (rdStrobe === 1'b1)
			addrQ.push_back(rdAddr);
		if (softReset === 1'b1) begin
			rstPulses++;
			busyCyc = 0;
		end
		if (busy === 1'b1)
			busyCyc++;
	end

	// expected packed settings
	function automatic logic [23:0] st(input logic m, input logic b, input logic [2:0] w,
		input logic [3:0] d, input logic [7:0] p);
		return 24'({m, b, w, d, p});
	endfunction

	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// one- and two-byte command frames
	task automatic cmd2(input logic quad, input logic [7:0] b0, input logic [7:0] b1, input int n);
		u_host.txq.push_back(b0);
		if (n > 1)
			u_host.txq.push_back(b1);
		u_host.frame(quad);
	endtask

	// read: opcode, address, dummy bytes, nd data bytes
	task automatic rd(input logic quad, input logic [7:0] opc, input logic [23:0] a, input int nd);
		logic [31:0] hdr;
		hdr = {opc, a};
		addrQ.delete();
		for (int i = 3; i >= 0; i--)
			u_host.txq.push_back(hdr[8*i +: 8]);
		repeat (dummyClocks / 2 + nd)
			u_host.txq.push_back(8'h00);
		u_host.frame(quad);
	endtask

	// strobed addresses against a window walk, win 0 meaning linear
	task automatic chkWalk(input logic [23:0] a, input int win, input int n);
		logic [23:0] e;
		e = a;
		chk(24'(addrQ.size() >= n), 24'h1, "strobe count");
		for (int i = 0; i < n && i < addrQ.size(); i++) begin
			chk(addrQ[i], e, "read address");
			e = (win == 0) ? e + 24'h1 :
				((e & ~24'(win - 1)) | ((e + 24'h1) & 24'(win - 1)));
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// watchdog well beyond the expected run of about 80 us
	initial begin
		#500000;
		n_mismatch++;
		$display("BAD %0t watchdog expired", $time);
		results();
	end

	// main sequence
	initial begin
		rstn        = 1'b0;
		quadEnable  = 1'b0;
		n_mismatch  = 0;
		check_count = 0;
		busyCyc     = 0;
		rstPulses   = 0;
		repeat (12) @(negedge clk_sys);
		rstn = 1'b1;
		@(negedge clk_sys);
		chk(24'(stat), st(0, 0, 3'h0, 4'h2, 8'h00), "power-up");
		cmd2(1'b0, 8'hC0, 8'h31, 2);
		chk(24'(stat), st(0, 0, 3'h0, 4'h2, 8'h00), "param in serial");
		cmd2(1'b0, 8'h38, 8'h00, 1);
		chk(24'(stat), st(0, 0, 3'h0, 4'h2, 8'h00), "enter without enable");
		cmd2(1'b0, 8'h77, 8'h60, 2);
		quadEnable = 1'b1;
		cmd2(1'b0, 8'h38, 8'h00, 1);
		chk(24'(stat), st(1, 0, 3'h6, 4'h2, 8'h00), "enter");
		cmd2(1'b1, 8'h77, 8'h10, 2);
		chk(24'(stat), st(1, 0, 3'h6, 4'h2, 8'h00), "serial-only command");
		for (int c = 0; c < 4; c++) begin
			cmd2(1'b1, 8'hC0, 8'(c << 4) | 8'h01, 2);
			chk(24'(stat), st(1, 0, 3'h6, 4'(2 + 2 * c), 8'(c << 4) | 8'h01), "set param");
		end
		rd(1'b1, 8'h0C, 24'h00001E, 3);
		chkWalk(24'h00001E, 16, 3);
		cmd2(1'b1, 8'hC0, 8'h02, 2);
		rd(1'b1, 8'h0C, 24'h00003F, 3);
		chkWalk(24'h00003F, 32, 3);
		rd(1'b1, 8'h0B, 24'h0000FE, 3);
		chkWalk(24'h0000FE, 0, 3);
		cmd2(1'b1, 8'h66, 8'h00, 1);
		cmd2(1'b1, 8'h05, 8'h00, 1);
		cmd2(1'b1, 8'h99, 8'h00, 1);
		chk(24'(rstPulses), 24'h0, "disarmed reset");
		chk(24'(stat), st(1, 0, 3'h6, 4'h2, 8'h02), "no reset");
		cmd2(1'b1, 8'hFF, 8'h00, 1);
		chk(24'({quadMode, wrapSetting}), 24'h6, "exit");
		rd(1'b0, 8'h0C, 24'h00003F, 2);
		chk(24'(addrQ.size()), 24'h0, "wrapped read in serial");
		u_host.waitIdle();
		cmd2(1'b0, 8'h66, 8'h00, 1);
		cmd2(1'b0, 8'h99, 8'h00, 1);
		chk(24'(stat), st(0, 1, 3'h0, 4'h2, 8'h00), "serial reset");
		u_host.waitIdle();
		chk(24'(busyCyc), 24'd1500, "recovery length");
		cmd2(1'b0, 8'h77, 8'h40, 2);
		cmd2(1'b0, 8'h38, 8'h00, 1);
		cmd2(1'b1, 8'hC0, 8'h21, 2);
		u_host.waitIdle();
		cmd2(1'b1, 8'h66, 8'h00, 1);
		cmd2(1'b1, 8'h99, 8'h00, 1);
		cmd2(1'b0, 8'h77, 8'h70, 2);
		chk(24'(stat), st(0, 1, 3'h0, 4'h2, 8'h00), "four-wire reset");
		u_host.waitIdle();
		chk(24'(busyCyc), 24'd1500, "recovery length");
		chk(24'(rstPulses), 24'h2, "reset pulses");
		chk(24'(wrapSetting), 24'h0, "command during recovery");
		cmd2(1'b0, 8'h38, 8'h00, 1);
		chk(24'(quadMode), 24'h1, "enter after recovery");
		results();
	end
endmodule
